//--- inc/bsfs_pkg.sv
// Package of constants and carrier types for the buck sequencer supervisor.
// -----------------------------------------------------------------------------
// Functional notes
// -----------------------------------------------------------------------------
// Functional notes
// [R1] Start only when enable high and input supply above lockout rising level.
// [R2] With supply already good, enable alone enables reference and starts.
// [R3] Wait fixed 300 us startup delay before soft-start and switching.
// [R4] Ramp reference at fixed rate; output ten to ninety percent in 0.2 ms; code ramps zero to full in 0.2 ms, ten to ninety in 0.16 ms.
// [R5] Oscillator sets switch latch each cycle; comparator trip resets it.
// [R6] At minimum off time with large duty, lower switching frequency adaptively.
// [R7] Input below target output enters dropout, high side held on.
// [R8] Supply-ok output held low until soft-start completes.
// [R9] Supply-ok released high while feedback inside the good window.
// [R10] Supply-ok pulled low when feedback crosses either fault level.
// [R11] Thresholds: 85 falling fault, 90 rising good, 115 / 110 percent.
// [R12] Current limit trip ends on-time; peak and valley limits equal initially.
// [R13] Three consecutive peak limits above short level fold valley to 80%.
// [R14] Feedback below 30% for 10 us: both switches off, enter hiccup.
// [R15] Hiccup waits 3.5 ms off before each retry.
// [R16] Over temperature turns switches off; restart when below recovery level.
// [R17] Every restart repeats soft-start; supply-ok low until it completes.
// [R18] Enable low or supply below falling lockout stops and resets to idle.
package bsfs_pkg;

   localparam int unsigned CLK_HZ         = 10_000_000;
   localparam int unsigned START_DELAY_US = 300;
   localparam int unsigned SOFT_START_US  = 200;
   localparam int unsigned SHORT_DEGL_US  = 10;
   localparam int unsigned HICCUP_US      = 3500;
   localparam int unsigned START_DELAY_CYC =
      START_DELAY_US * (CLK_HZ / 1_000_000);
   localparam int unsigned SOFT_START_CYC =
      SOFT_START_US * (CLK_HZ / 1_000_000);
   localparam int unsigned SHORT_DEGL_CYC =
      SHORT_DEGL_US * (CLK_HZ / 1_000_000);
   localparam int unsigned HICCUP_CYC =
      HICCUP_US * (CLK_HZ / 1_000_000);

   // Reference ramp code, full scale equals the regulated reference.
   localparam int unsigned REF_W        = 8;
   localparam logic [7:0]  REF_FULL     = 8'hff;
   localparam int unsigned PEAK_RUN_MAX = 3;
   localparam logic [1:0]  PEAK_RUN_LIM = 2'h3;
   // Valley reference in percent of the peak limit.
   localparam logic [6:0]  VALLEY_FULL  = 7'h64;
   localparam logic [6:0]  VALLEY_FOLD  = 7'h50;

   // Window comparator outputs from the analog stage.
   typedef struct packed {
      logic below_fault_falling;   // Under 85 percent of reference.
      logic above_good_rising;     // Over 90 percent of reference.
      logic above_fault_rising;    // Over 115 percent of reference.
      logic below_good_falling;    // Under 110 percent of reference.
      logic below_short_level;     // Under 30 percent of reference.
   } bsfs_fb_s;

   // Switch drive outputs.
   typedef struct packed {
      logic high_side_on;
      logic low_side_on;
   } bsfs_drive_s;

   typedef enum logic [2:0] {
      ST_IDLE, ST_DELAY, ST_SOFT, ST_RUN, ST_HICCUP, ST_THERMAL
   } bsfs_state_e;

endpackage

//--- rtl/bsfs_sync.sv
// Two-stage synchroniser for a bundle of asynchronous input levels.
`timescale 1ns/1ps
module bsfs_sync #(
   parameter int unsigned WIDTH = 1
) (
   input  wire logic             ref_clk,
   input  wire logic             rst_b,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_reg;

   initial begin
      if (WIDTH < 1) $error("bsfs_sync needs WIDTH of at least one");
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_reg <= '0;
         sync_out <= '0;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule

//--- rtl/bsfs_top.sv
// Sequencer and fault supervisor of a synchronous step-down converter.
`timescale 1ns/1ps
module bsfs_top
   import bsfs_pkg::*;
#(
   parameter int unsigned HICCUP_CYCLES = HICCUP_CYC
) (
   input  wire logic        ref_clk,
   input  wire logic        rst_b,
   input  wire logic        enable_in,
   input  wire logic        input_lockout_ok,
   input  wire logic        input_above_target,
   input  wire logic        thermal_over,
   input  wire logic        thermal_recovered,
   input  wire bsfs_fb_s    feedback_sense,
   input  wire logic        osc_cycle_start,
   input  wire logic        modulation_trip,
   input  wire logic        peak_limit_trip,
   input  wire logic        min_off_reached,
   output bsfs_drive_s      switch_node,
   output logic [7:0]       soft_ref_code,
   output logic [6:0]       valley_limit_pct,
   output logic             reference_enable,
   output logic             freq_foldback,
   output logic             supply_ok_output_o,
   output logic             supply_ok_output_oe
);
   localparam int unsigned CNT_W = 16;

   initial begin
      if (HICCUP_CYCLES < 1 || HICCUP_CYCLES >= (1 << CNT_W))
         $error("bsfs_top HICCUP_CYCLES out of counter range");
   end

   // --------------------------------------------------------------------------
   // Input synchronisation
   // --------------------------------------------------------------------------
   localparam int unsigned NIN = 14;
   logic [NIN-1:0] raw_in;
   logic [NIN-1:0] syn;
   assign raw_in = {enable_in, input_lockout_ok, input_above_target,
                    thermal_over, thermal_recovered, feedback_sense,
                    osc_cycle_start, modulation_trip, peak_limit_trip,
                    min_off_reached};

   bsfs_sync #(.WIDTH(NIN)) u_sync (
      .ref_clk  (ref_clk),
      .rst_b    (rst_b),
      .async_in (raw_in),
      .sync_out (syn)
   );

   logic     en_s, uv_ok_s, above_tgt_s, hot_s, cool_s;
   logic     osc_s, mod_s, peak_s, minoff_s;
   bsfs_fb_s fb_s;
   assign {en_s, uv_ok_s, above_tgt_s, hot_s, cool_s, fb_s,
           osc_s, mod_s, peak_s, minoff_s} = syn;

   // --------------------------------------------------------------------------
   // Sequencer state
   // --------------------------------------------------------------------------
   bsfs_state_e      state_reg;
   logic [CNT_W-1:0] timer_reg;
   logic [CNT_W-1:0] short_cnt_reg;
   logic             osc_d_reg;
   logic             latch_reg;
   logic [1:0]       peak_run_reg;
   logic             ss_done_reg;
   logic             start_ok;
   logic             short_hit;
   logic             osc_rise;

   assign start_ok  = en_s && uv_ok_s;                      // [R1] [R2]
   assign short_hit = (short_cnt_reg == CNT_W'(SHORT_DEGL_CYC));
   assign osc_rise  = osc_s && !osc_d_reg;

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= ST_IDLE;
         timer_reg <= '0;
      end else if (!start_ok) begin
         state_reg <= ST_IDLE;                              // [R18]
         timer_reg <= '0;
      end else begin
         unique case (state_reg)
            ST_IDLE: begin
               state_reg <= ST_DELAY;                       // [R1]
               timer_reg <= '0;
            end
            ST_DELAY: begin
               if (timer_reg == CNT_W'(START_DELAY_CYC - 1)) begin
                  state_reg <= ST_SOFT;                     // [R3]
                  timer_reg <= '0;
               end else begin
                  timer_reg <= timer_reg + 1'b1;
               end
            end
            ST_SOFT, ST_RUN: begin
               if (hot_s) begin
                  state_reg <= ST_THERMAL;                  // [R16]
                  timer_reg <= '0;
               end else if (short_hit) begin
                  state_reg <= ST_HICCUP;                   // [R14]
                  timer_reg <= '0;
               end else if (state_reg == ST_SOFT) begin
                  if (timer_reg == CNT_W'(SOFT_START_CYC - 1)) begin
                     state_reg <= ST_RUN;
                     timer_reg <= '0;
                  end else begin
                     timer_reg <= timer_reg + 1'b1;         // [R4]
                  end
               end
            end
            ST_HICCUP: begin
               if (timer_reg == CNT_W'(HICCUP_CYCLES - 1)) begin
                  state_reg <= ST_SOFT;                     // [R15] [R17]
                  timer_reg <= '0;
               end else begin
                  timer_reg <= timer_reg + 1'b1;
               end
            end
            ST_THERMAL: begin
               if (cool_s && !hot_s) begin
                  state_reg <= ST_SOFT;                     // [R16] [R17]
                  timer_reg <= '0;
               end
            end
         endcase
      end
   end

   // Short-circuit deglitch; only counted while the stage is switching.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         short_cnt_reg <= '0;
      end else if ((state_reg == ST_SOFT || state_reg == ST_RUN) &&
                   fb_s.below_short_level && !short_hit) begin
         short_cnt_reg <= short_cnt_reg + 1'b1;             // [R14]
      end else begin
         short_cnt_reg <= '0;
      end
   end

   // --------------------------------------------------------------------------
   // Soft-start reference ramp
   // --------------------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         soft_ref_code    <= '0;
         ss_done_reg      <= 1'b0;
         reference_enable <= 1'b0;
      end else begin
         reference_enable <= start_ok;                      // [R2]
         if (state_reg == ST_SOFT) begin
            soft_ref_code <= 8'((32'(timer_reg) * 32'(REF_FULL))
                                / SOFT_START_CYC);          // [R4]
            ss_done_reg   <= 1'b0;                          // [R17]
         end else if (state_reg == ST_RUN) begin
            soft_ref_code <= REF_FULL;
            ss_done_reg   <= 1'b1;
         end else begin
            soft_ref_code <= '0;
            ss_done_reg   <= 1'b0;
         end
      end
   end

   // --------------------------------------------------------------------------
   // Switch latch, dropout and frequency foldback
   // --------------------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         osc_d_reg     <= 1'b0;
         latch_reg     <= 1'b0;
         freq_foldback <= 1'b0;
      end else begin
         osc_d_reg <= osc_s;
         if (state_reg != ST_SOFT && state_reg != ST_RUN) begin
            latch_reg     <= 1'b0;
            freq_foldback <= 1'b0;
         end else begin
            freq_foldback <= minoff_s;                     // [R6]
            if (mod_s || peak_s) begin
               latch_reg <= 1'b0;                           // [R5] [R12]
            end else if (osc_rise && !(minoff_s && latch_reg)) begin
               latch_reg <= 1'b1;                           // [R5] [R6]
            end
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         switch_node <= '0;
      end else if (state_reg != ST_SOFT && state_reg != ST_RUN) begin
         switch_node <= '0;                                 // [R14] [R16]
      end else if (!above_tgt_s && !peak_s) begin
         switch_node.high_side_on <= 1'b1;                  // [R7]
         switch_node.low_side_on  <= 1'b0;
      end else begin
         switch_node.high_side_on <= latch_reg;
         switch_node.low_side_on  <= !latch_reg;
      end
   end

   // --------------------------------------------------------------------------
   // Current-limit foldback
   // --------------------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         peak_run_reg     <= '0;
         valley_limit_pct <= VALLEY_FULL;
      end else if (state_reg != ST_SOFT && state_reg != ST_RUN) begin
         peak_run_reg     <= '0;
         valley_limit_pct <= VALLEY_FULL;                   // [R12]
      end else if (osc_rise) begin
         if (!peak_s && !latch_reg) begin
            peak_run_reg <= '0;
         end else if (peak_s && !fb_s.below_short_level &&
                      peak_run_reg != PEAK_RUN_LIM) begin
            peak_run_reg <= peak_run_reg + 1'b1;
         end
         if (peak_run_reg == 2'(PEAK_RUN_MAX)) begin
            valley_limit_pct <= VALLEY_FOLD;                // [R13]
         end else begin
            valley_limit_pct <= VALLEY_FULL;
         end
      end else if (peak_s && !fb_s.below_short_level &&
                   peak_run_reg == 2'(PEAK_RUN_MAX - 1)) begin
         peak_run_reg     <= PEAK_RUN_LIM;
         valley_limit_pct <= VALLEY_FOLD;                   // [R13]
      end
   end

   // --------------------------------------------------------------------------
   // Supply-ok open-drain output
   // --------------------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         supply_ok_output_oe <= 1'b1;
         supply_ok_output_o  <= 1'b0;
      end else begin
         supply_ok_output_o <= 1'b0;
         if (!ss_done_reg || state_reg != ST_RUN) begin
            supply_ok_output_oe <= 1'b1;                    // [R8] [R17]
         end else if (fb_s.below_fault_falling ||
                      fb_s.above_fault_rising) begin
            supply_ok_output_oe <= 1'b1;                    // [R10] [R11]
         end else if (fb_s.above_good_rising &&
                      fb_s.below_good_falling) begin
            supply_ok_output_oe <= 1'b0;                    // [R9] [R11]
         end
      end
   end
endmodule

//--- tb/bsfs_checker_assertions.sv
// Concurrent checks on the ports of the sequencer supervisor.
`timescale 1ns/1ps
module bsfs_checker
   import bsfs_pkg::*;
#(
   parameter int unsigned HICCUP_CYCLES = HICCUP_CYC
) (
   input wire logic        ref_clk,
   input wire logic        rst_b,
   input wire logic        enable_in,
   input wire logic        input_lockout_ok,
   input wire logic        input_above_target,
   input wire logic        thermal_over,
   input wire logic        thermal_recovered,
   input wire bsfs_fb_s    feedback_sense,
   input wire logic        osc_cycle_start,
   input wire logic        modulation_trip,
   input wire logic        peak_limit_trip,
   input wire logic        min_off_reached,
   input wire bsfs_drive_s switch_node,
   input wire logic [7:0]  soft_ref_code,
   input wire logic [6:0]  valley_limit_pct,
   input wire logic        reference_enable,
   input wire logic        freq_foldback,
   input wire logic        supply_ok_output_o,
   input wire logic        supply_ok_output_oe
);
   int unsigned en_cnt_reg;
   int unsigned short_cnt_reg;
   logic        fb_good;

   // Feedback inside the good window with the ramp finished.
   assign fb_good = feedback_sense == 5'h0a && !thermal_over
                    && reference_enable && soft_ref_code == REF_FULL;

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) en_cnt_reg <= 0;
      else en_cnt_reg <= reference_enable ? en_cnt_reg + 1 : 0;
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) short_cnt_reg <= 0;
      else short_cnt_reg <= feedback_sense.below_short_level ?
                            short_cnt_reg + 1 : 0;
   end

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   delay_quiet_a:
      assert property (en_cnt_reg inside {[1:2999]} |->
                       switch_node == '0 && soft_ref_code == 8'h00)
      else $error("Switching or ramp inside the startup delay.");
   good_held_a:
      assert property (en_cnt_reg inside {[1:4999]} |-> supply_ok_output_oe)
      else $error("Supply ok released before soft-start end.");
   good_window_a:
      assert property (fb_good[*8] |-> !supply_ok_output_oe)
      else $error("Supply ok not released in the good window.");
   fault_pull_a:
      assert property ((feedback_sense.below_fault_falling ||
                        feedback_sense.above_fault_rising)[*6]
                       |-> supply_ok_output_oe)
      else $error("Supply ok not pulled low on a fault level.");
   stop_idle_a:
      assert property ((!enable_in || !input_lockout_ok)[*6] |->
                       !reference_enable && supply_ok_output_oe
                       && switch_node == '0)
      else $error("Not idle without enable and supply.");
   thermal_off_a:
      assert property (thermal_over[*6] |-> switch_node == '0)
      else $error("Switches on during over temperature.");
   short_off_a:
      assert property (short_cnt_reg == 110 |-> switch_node == '0)
      else $error("Switches on after the short deglitch time.");
   peak_off_a:
      assert property (peak_limit_trip[*3] |-> ##2
                       !switch_node.high_side_on)
      else $error("High side on after a peak limit trip.");
   valley_code_a:
      assert property (valley_limit_pct == VALLEY_FULL ||
                       valley_limit_pct == VALLEY_FOLD)
      else $error("Valley limit code out of range.");
   dropout_on_a:
      assert property ((!input_above_target && !peak_limit_trip
                        && fb_good)[*6] |-> switch_node.high_side_on)
      else $error("High side not held on in dropout.");
endmodule

//--- tb/bsfs_partner.sv
// Enable driver and pulled-up supply-ok line of the system side.
`timescale 1ns/1ps
module bsfs_partner (
   input  wire logic ref_clk,
   input  wire logic en_req,
   input  wire logic pg_o,
   input  wire logic pg_oe,
   output logic      enable_in,
   output wire logic pg_line
);
   initial enable_in = 1'b0;
   always @(posedge ref_clk) begin
      enable_in <= en_req;
   end
   // A released open-drain line reads the pull-up level.
   assign pg_line = pg_oe ? pg_o : 1'b1;
endmodule

//--- tb/testbench.sv
// Self-checking bench for the buck sequencer supervisor.
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin mismatches++; \
   $display("BAD %0t got %h exp %h", $time, a, e); end end
module testbench;
   import bsfs_pkg::*;
   localparam int unsigned HIC_CYC = 50;
   logic        ref_clk = 1'b0, rst_b = 1'b0, en_req = 1'b0;
   logic        input_lockout_ok = 1'b0, input_above_target = 1'b1;
   logic        thermal_over = 1'b0, thermal_recovered = 1'b1;
   bsfs_fb_s    feedback_sense = 5'h0a;
   logic        osc_cycle_start = 1'b0, modulation_trip = 1'b0;
   logic        peak_limit_trip = 1'b0, min_off_reached = 1'b0;
   logic [1:0]  osc_cnt = 2'h0;
   wire         enable_in, reference_enable, freq_foldback;
   wire         pg_o, pg_oe, pg_line;
   bsfs_drive_s switch_node;
   logic [7:0]  soft_ref_code;
   logic [6:0]  valley_limit_pct;
   int          mismatches = 0, compares = 0, cyc = 0;

   bsfs_top #(.HICCUP_CYCLES(HIC_CYC)) dut (
      .ref_clk(ref_clk), .rst_b(rst_b), .enable_in(enable_in),
      .input_lockout_ok(input_lockout_ok),
      .input_above_target(input_above_target),
      .thermal_over(thermal_over), .thermal_recovered(thermal_recovered),
      .feedback_sense(feedback_sense), .osc_cycle_start(osc_cycle_start),
      .modulation_trip(modulation_trip), .peak_limit_trip(peak_limit_trip),
      .min_off_reached(min_off_reached), .switch_node(switch_node),
      .soft_ref_code(soft_ref_code), .valley_limit_pct(valley_limit_pct),
      .reference_enable(reference_enable), .freq_foldback(freq_foldback),
      .supply_ok_output_o(pg_o), .supply_ok_output_oe(pg_oe));
   bsfs_partner partner (.ref_clk(ref_clk), .en_req(en_req), .pg_o(pg_o),
      .pg_oe(pg_oe), .enable_in(enable_in), .pg_line(pg_line));

   // -------------------------------------------------------------------
   // Clock, oscillator and hang guard
   // -------------------------------------------------------------------
   always #50 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      osc_cnt <= osc_cnt + 2'h1;
      osc_cycle_start <= osc_cnt[1];
      modulation_trip <= osc_cnt == 2'h3;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         mismatches++;
         final_report();
      end
   end

   task automatic step(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   task automatic final_report();
      $display("mismatches %0d compares %0d", mismatches, compares);
      if (mismatches == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // -------------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------------
   task automatic t_gate();
      en_req <= 1'b1;
      step(40);
      `CHK(reference_enable, 1'b0)
      en_req <= 1'b0;
      input_lockout_ok <= 1'b1;
      step(40);
      `CHK(reference_enable, 1'b0)
   endtask

   task automatic t_start();
      int n_on = 0;
      en_req <= 1'b1;
      step(20);
      `CHK(reference_enable, 1'b1)
      step(2900);
      `CHK({switch_node, soft_ref_code}, 10'h000)
      step(1000);
      `CHK(pg_line, 1'b0)
      `CHK(soft_ref_code > 8'h60 && soft_ref_code < 8'h88, 1'b1)
      step(1200);
      `CHK(soft_ref_code, REF_FULL)
      `CHK(pg_line, 1'b1)
      `CHK(valley_limit_pct, VALLEY_FULL)
      // One oscillator period sets the high side once and trips it once.
      repeat (4) begin
         step(1);
         n_on += switch_node.high_side_on;
      end
      `CHK(n_on, 1)
   endtask

   task automatic t_window();
      for (int i = 0; i < 2; i++) begin
         feedback_sense <= i ? 5'h0c : 5'h12;
         step(10);
         `CHK(pg_line, 1'b0)
         feedback_sense <= 5'h0a;
         step(10);
         `CHK(pg_line, 1'b1)
      end
   endtask

   task automatic t_fold();
      for (int i = 0; i < 3; i++) begin
         `CHK(valley_limit_pct, VALLEY_FULL)
         peak_limit_trip <= 1'b1;
         step(3);
         peak_limit_trip <= 1'b0;
         step(1);
      end
      step(6);
      `CHK(valley_limit_pct, VALLEY_FOLD)
   endtask

   task automatic t_drop();
      input_above_target <= 1'b0;
      min_off_reached <= 1'b1;
      step(12);
      `CHK(switch_node.high_side_on, 1'b1)
      `CHK(freq_foldback, 1'b1)
      input_above_target <= 1'b1;
      min_off_reached <= 1'b0;
      step(12);
      `CHK(freq_foldback, 1'b0)
   endtask

   task automatic t_short();
      feedback_sense <= 5'h13;
      step(115);
      `CHK(switch_node, 2'h0)
      feedback_sense <= 5'h0a;
      step(HIC_CYC - 20);
      `CHK(switch_node, 2'h0)
      step(970);
      `CHK(pg_line, 1'b0)
      step(1200);
      `CHK(pg_line, 1'b1)
   endtask

   task automatic t_thermal();
      thermal_over <= 1'b1;
      thermal_recovered <= 1'b0;
      step(8);
      `CHK(switch_node, 2'h0)
      thermal_over <= 1'b0;
      step(20);
      `CHK(switch_node, 2'h0)
      thermal_recovered <= 1'b1;
      step(1000);
      `CHK(pg_line, 1'b0)
      step(1100);
      `CHK(pg_line, 1'b1)
   endtask

   task automatic t_stop();
      en_req <= 1'b0;
      step(8);
      `CHK({reference_enable, pg_line, switch_node}, 4'h0)
      en_req <= 1'b1;
      step(20);
      `CHK(reference_enable, 1'b1)
      input_lockout_ok <= 1'b0;
      step(8);
      `CHK({reference_enable, pg_line, switch_node}, 4'h0)
   endtask

   initial begin
      step(2);
      rst_b <= 1'b1;
      step(3);
      t_gate();
      t_start();
      t_window();
      t_fold();
      t_drop();
      t_short();
      t_thermal();
      t_stop();
      final_report();
   end
endmodule

bind bsfs_top bsfs_checker #(.HICCUP_CYCLES(HICCUP_CYCLES)) u_chk (
   .ref_clk(ref_clk), .rst_b(rst_b), .enable_in(enable_in),
   .input_lockout_ok(input_lockout_ok),
   .input_above_target(input_above_target), .thermal_over(thermal_over),
   .thermal_recovered(thermal_recovered), .feedback_sense(feedback_sense),
   .osc_cycle_start(osc_cycle_start), .modulation_trip(modulation_trip),
   .peak_limit_trip(peak_limit_trip), .min_off_reached(min_off_reached),
   .switch_node(switch_node), .soft_ref_code(soft_ref_code),
   .valley_limit_pct(valley_limit_pct), .freq_foldback(freq_foldback),
   .reference_enable(reference_enable),
   .supply_ok_output_o(supply_ok_output_o),
   .supply_ok_output_oe(supply_ok_output_oe));
